// ---- src/nested_irq_map.vh ----
// Purpose: Register offsets, field positions and codes of the nested interrupt controller
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef NESTED_IRQ_MAP_VH
`define NESTED_IRQ_MAP_VH

// --------------------------------------------------------------------------
// Register byte addresses
// --------------------------------------------------------------------------
`define ADR_PRIO0      6'h00
`define ADR_PRIO1      6'h04
`define ADR_PRIO2      6'h08
`define ADR_PRIO3      6'h0C
`define ADR_SENS       6'h10
`define ADR_CCR        6'h14
`define ADR_CPU_OP     6'h18
`define ADR_STATUS     6'h1C
`define ADR_PEND       6'h20
`define ADR_REQ_EN     6'h24
`define ADR_HALT_CTL   6'h28

// --------------------------------------------------------------------------
// Condition-code layout and levels
// --------------------------------------------------------------------------
`define CC_RESET       8'hEA
`define CC_LVL_HI      5
`define CC_LVL_LO      3
`define LVL_CODE_0     2'h2
`define LVL_CODE_1     2'h1
`define LVL_CODE_2     2'h0
`define LVL_CODE_3     2'h3
`define PRIO_RESET     8'hFF
`define PRIO3_RO_MASK  8'hF0
`define SENS_RESET     8'h00
`define SENS_WR_MASK   8'hFC

// --------------------------------------------------------------------------
// Sources and vectors
// --------------------------------------------------------------------------
`define NSRC           14
`define SRC_TIMEBASE   1
`define SRC_EXT0       2
`define SRC_EXT1       3
`define SRC_EXT2       4
`define SRC_EXT3       5
`define SRC_SYNC_SER   7
`define SRC_TIMER_A    8
`define SRC_TIMER_B    9
`define SRC_ASYNC_SER  10
`define VEC_RESET      8'hFE
`define VEC_TRAP       8'hFC
`define VEC_TOP_MASK   8'hFA
`define WAKE_FULL      14'h00BC
`define WAKE_ACT_FLASH 14'h0002
`define WAKE_ACT_ROM   14'h00BE

// --------------------------------------------------------------------------
// Sensitivity register fields and modes
// --------------------------------------------------------------------------
`define SENS_B_FIELD   7:6
`define SENS_B_INV     5
`define SENS_A_FIELD   4:3
`define SENS_A_INV     2
`define MODE_EDGE_LVL  2'h0
`define MODE_RISE      2'h1
`define MODE_FALL      2'h2
`define MODE_BOTH      2'h3

// --------------------------------------------------------------------------
// CPU operation codes written to the operation register
// --------------------------------------------------------------------------
`define OP_NONE        3'h0
`define OP_ENABLE      3'h1
`define OP_DISABLE     3'h2
`define OP_HALT        3'h3
`define OP_WAIT        3'h4
`define OP_TRAP        3'h5
`define OP_RETURN      3'h6
`define OP_POP_CC      3'h7

`endif

// ---- src/nested_irq_ctrl.v ----
// Purpose: Nested priority interrupt controller with Wishbone register access
// Assumes: Single clock, synchronous active-high reset, CPU side as register ops
// Notes:   Stack of saved condition codes kept in a small internal array
//
// Summary of operation
// R1 - Lower source number wins fixed priority
// R2 - Concurrent or nested servicing by level
// R3 - Level pair in condition bits 5,3
// R4 - Condition code resets to 111x1010
// R5 - Entry loads level from vector pair
// R6 - Instructions load, set or restore level
// R7 - Masked and unmasked branch conditions provided
// R8 - Reset and trap override level three
// R9 - Priority registers reset to ones
// R10 - Fourteen pairs, pair 0 at top
// R11 - Level-0 pair writes are ignored
// R12 - Rewritten pair re-enters only if higher
// R13 - Level instructions persist until return
// R14 - Fixed vector map for all sources
// R15 - Full halt wake sources restricted
// R16 - Active halt wake depends on variant
// R17 - Four edge modes, level on groups 0,2
// R18 - Four sensitivities via inversion and fields
// R19 - Sensitivity writes accepted only at level 3
// R20 - Writing level 3 clears external pending
// R21 - No stack overflow indication
// R22 - Highest level first, then hardware order
// R23 - Unserviced requests latched as pending
// R24 - Entry after instruction, context stacked
// R25 - Level mode re-asserts while pin active
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "nested_irq_map.vh"

module nested_irq_ctrl #(
  parameter ROM_VARIANT = 0
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [5:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire [13:0] periph_req_i,
  input  wire [3:0]  ext_line_i,
  input  wire        insn_done_i,
  output reg         irq_take_o,
  output reg  [7:0]  vector_o,
  output reg         branch_if_masked_o,
  output reg         branch_if_unmasked_o,
  output reg         wake_o
);

  // ------------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------------
  // Rank of a level code: 0 lowest .. 3 highest
  function [1:0] rank;
    input [1:0] code;
    begin
      case (code)
        `LVL_CODE_0: rank = 2'd0;
        `LVL_CODE_1: rank = 2'd1;
        `LVL_CODE_2: rank = 2'd2;
        default:     rank = 2'd3;
      endcase
    end
  endfunction

  // Merge a byte write into priority pairs, keeping pairs written with level 0
  function [7:0] merge_prio;
    input [7:0] old_v;
    input [7:0] new_v;
    integer k;
    begin
      merge_prio = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (new_v[2*k+1 -: 2] != `LVL_CODE_0) begin // R11
          merge_prio[2*k+1 -: 2] = new_v[2*k+1 -: 2];
        end
      end
    end
  endfunction

  // Edge/level detection for one line
  function detect;
    input       prev;
    input       cur;
    input [1:0] mode;
    input       inv;
    reg         p;
    reg         c;
    begin
      p = prev ^ inv;
      c = cur ^ inv;
      case (mode)
        `MODE_EDGE_LVL: detect = ~c; // R17 R25
        `MODE_RISE:     detect = c & ~p;
        `MODE_FALL:     detect = ~c & p;
        default:        detect = c ^ p;
      endcase
    end
  endfunction

  // ------------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------------
  reg  [7:0]  prio_r [0:3];
  reg  [7:0]  sens_r;
  reg  [7:0]  cc_r;
  reg  [7:0]  cc_stack_r [0:7];
  reg  [2:0]  sp_r;
  reg  [13:0] pend_r;
  reg  [13:0] req_en_r;
  reg  [3:0]  ext_prev_r;
  reg  [3:0]  src_r;
  reg         trap_pend_r;
  reg         boot_r;
  reg         halted_r;
  reg         active_halt_r;
  reg  [27:0] prio_flat;
  reg  [13:0] ext_hits;
  reg  [13:0] cand;
  reg  [3:0]  win;
  reg         win_v;
  reg  [1:0]  win_rank;
  reg  [1:0]  win_code;
  reg  [1:0]  lvl;
  reg         mode_ok;
  reg  [13:0] wake_set;
  integer     i;
  integer     j;

  wire        wr_acc = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  wire [1:0]  cur_lvl = {cc_r[`CC_LVL_HI], cc_r[`CC_LVL_LO]}; // R3

  // ------------------------------------------------------------------------
  // Request detection and arbitration
  // ------------------------------------------------------------------------
  always @* begin
    prio_flat = {prio_r[3][3:0], prio_r[2], prio_r[1], prio_r[0]}; // R10
    ext_hits = 14'h0000;
    ext_hits[`SRC_EXT0] = detect(ext_prev_r[0], ext_line_i[0], sens_r[`SENS_A_FIELD],
                                 sens_r[`SENS_A_INV]); // R18
    ext_hits[`SRC_EXT1] = detect(ext_prev_r[1], ext_line_i[1], sens_r[`SENS_A_FIELD], 1'b0);
    ext_hits[`SRC_EXT2] = detect(ext_prev_r[2], ext_line_i[2], sens_r[`SENS_B_FIELD],
                                 sens_r[`SENS_B_INV]);
    ext_hits[`SRC_EXT3] = detect(ext_prev_r[3], ext_line_i[3], sens_r[`SENS_B_FIELD], 1'b0);
    cand = pend_r & req_en_r;
    win = 4'h0;
    win_v = 1'b0;
    win_rank = 2'd0;
    win_code = `LVL_CODE_3;
    lvl = `LVL_CODE_3;
    for (j = `NSRC - 1; j >= 0; j = j - 1) begin
      lvl = prio_flat[2*j+1 -: 2];
      // Strictly higher than running level; ties keep lower index
      if (cand[j] && lvl != `LVL_CODE_3 && rank(lvl) > rank(cur_lvl) &&
          (!win_v || rank(lvl) >= win_rank)) begin // R22 R1 R2
        win = j[3:0];
        win_v = 1'b1;
        win_rank = rank(lvl);
        win_code = lvl;
      end
    end
    wake_set = ROM_VARIANT ? `WAKE_ACT_ROM : `WAKE_ACT_FLASH;
    mode_ok = active_halt_r ? |(cand & wake_set) : |(cand & `WAKE_FULL); // R15 R16
  end

  // ------------------------------------------------------------------------
  // Main sequential logic
  // ------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        prio_r[i] <= `PRIO_RESET; // R9
      end
      for (i = 0; i < 8; i = i + 1) begin
        cc_stack_r[i] <= 8'h00;
      end
      sens_r <= `SENS_RESET;
      cc_r <= `CC_RESET; // R4
      sp_r <= 3'h0;
      pend_r <= 14'h0000;
      req_en_r <= 14'h0000;
      ext_prev_r <= 4'hF;
      src_r <= 4'hF;
      trap_pend_r <= 1'b0;
      boot_r <= 1'b1;
      halted_r <= 1'b0;
      active_halt_r <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      irq_take_o <= 1'b0;
      vector_o <= 8'h00;
      branch_if_masked_o <= 1'b0;
      branch_if_unmasked_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      ext_prev_r <= ext_line_i;
      irq_take_o <= 1'b0;
      wake_o <= 1'b0;
      branch_if_masked_o <= (cur_lvl == `LVL_CODE_3); // R7
      branch_if_unmasked_o <= (cur_lvl != `LVL_CODE_3); // R7
      ack_o <= cyc_i & stb_i & ~ack_o;
      // Latch requests; set wins over any write clear in the same cycle, but only ext_hits re-sets the line cleared on entry
      pend_r <= pend_r | periph_req_i | ext_hits; // R23
      if (boot_r) begin
        boot_r <= 1'b0;
        irq_take_o <= 1'b1;
        vector_o <= `VEC_RESET; // R14 R8
      end else if (insn_done_i && trap_pend_r) begin
        trap_pend_r <= 1'b0;
        cc_stack_r[sp_r] <= cc_r; // R24
        sp_r <= sp_r + 3'h1; // R21
        cc_r[`CC_LVL_HI] <= 1'b1; // R8 R6
        cc_r[`CC_LVL_LO] <= 1'b1;
        irq_take_o <= 1'b1;
        vector_o <= `VEC_TRAP;
        halted_r <= 1'b0;
      end else if (halted_r && mode_ok) begin
        halted_r <= 1'b0; // R15
        wake_o <= 1'b1;
      end else if (!halted_r && insn_done_i && win_v) begin
        cc_stack_r[sp_r] <= cc_r; // R24
        sp_r <= sp_r + 3'h1; // R21
        cc_r[`CC_LVL_HI] <= win_code[1]; // R5 R2
        cc_r[`CC_LVL_LO] <= win_code[0];
        src_r <= win;
        irq_take_o <= 1'b1;
        vector_o <= `VEC_TOP_MASK - {3'h0, win, 1'b0}; // R10 R14
        // The winning external line's edge latch clears on entry
        pend_r <= (pend_r | periph_req_i | ext_hits) &
                  ~((14'h0001 << win) & 14'h003C) | (ext_hits & 14'h003C); // R25
      end
      if (wr_acc) begin
        if (adr_i == `ADR_PRIO0 || adr_i == `ADR_PRIO1 || adr_i == `ADR_PRIO2) begin
          prio_r[adr_i[3:2]] <= merge_prio(prio_r[adr_i[3:2]], dat_i[7:0]); // R11 R12
          for (i = 0; i < 4; i = i + 1) begin
            if (dat_i[2*i+1 -: 2] == `LVL_CODE_3 &&
                ({adr_i[3:2], 2'b00} + i) >= `SRC_EXT0 &&
                ({adr_i[3:2], 2'b00} + i) <= `SRC_EXT3) begin
              // Clear pending, but a new arrival in the same cycle wins
              pend_r[{adr_i[3:2], 2'b00} + i] <= periph_req_i[{adr_i[3:2], 2'b00} + i] |
                                                 ext_hits[{adr_i[3:2], 2'b00} + i]; // R20
            end
          end
        end else if (adr_i == `ADR_PRIO3) begin
          prio_r[3] <= merge_prio(prio_r[3], dat_i[7:0]) | `PRIO3_RO_MASK; // R9
        end else if (adr_i == `ADR_SENS) begin
          if (cur_lvl == `LVL_CODE_3) begin
            sens_r <= dat_i[7:0] & `SENS_WR_MASK; // R19
          end
        end else if (adr_i == `ADR_CCR) begin
          cc_r <= dat_i[7:0];
        end else if (adr_i == `ADR_CPU_OP) begin
          case (dat_i[2:0]) // R6 R13
            `OP_ENABLE: begin
              cc_r[`CC_LVL_HI] <= 1'b1;
              cc_r[`CC_LVL_LO] <= 1'b0;
            end
            `OP_DISABLE: begin
              cc_r[`CC_LVL_HI] <= 1'b1;
              cc_r[`CC_LVL_LO] <= 1'b1;
            end
            `OP_HALT, `OP_WAIT: begin
              cc_r[`CC_LVL_HI] <= 1'b1;
              cc_r[`CC_LVL_LO] <= 1'b0;
              halted_r <= (dat_i[2:0] == `OP_HALT);
            end
            `OP_TRAP: begin
              trap_pend_r <= 1'b1;
            end
            `OP_RETURN: begin
              cc_r <= cc_stack_r[sp_r - 3'h1];
              sp_r <= sp_r - 3'h1;
            end
            `OP_POP_CC: begin
              cc_r <= dat_i[15:8];
            end
            default: begin
              cc_r <= cc_r;
            end
          endcase
        end else if (adr_i == `ADR_PEND) begin
          // Write one to clear; new arrivals still win
          pend_r <= (pend_r & ~dat_i[13:0]) | periph_req_i | ext_hits;
        end else if (adr_i == `ADR_REQ_EN) begin
          req_en_r <= dat_i[13:0];
        end else if (adr_i == `ADR_HALT_CTL) begin
          active_halt_r <= dat_i[0];
        end
      end
      if (cyc_i && stb_i && !we_i && !ack_o) begin
        if (adr_i == `ADR_PRIO0 || adr_i == `ADR_PRIO1 || adr_i == `ADR_PRIO2 ||
            adr_i == `ADR_PRIO3) begin
          dat_o <= {24'h000000, prio_r[adr_i[3:2]]};
        end else if (adr_i == `ADR_SENS) begin
          dat_o <= {24'h000000, sens_r};
        end else if (adr_i == `ADR_CCR) begin
          dat_o <= {24'h000000, cc_r};
        end else if (adr_i == `ADR_STATUS) begin
          dat_o <= {22'h000000, halted_r, win_v, win, sp_r, trap_pend_r};
        end else if (adr_i == `ADR_PEND) begin
          dat_o <= {14'h0000, src_r, pend_r};
        end else if (adr_i == `ADR_REQ_EN) begin
          dat_o <= {18'h00000, req_en_r};
        end else if (adr_i == `ADR_HALT_CTL) begin
          dat_o <= {31'h00000000, active_halt_r};
        end else begin
          dat_o <= 32'h00000000;
        end
      end
    end
  end

endmodule

// ---- verification/nested_irq_ctrl_assertions.sv ----
// Purpose: Port checks of nested_irq_ctrl
// Assumes: One clock, sync reset
// Notes:   Bound to every instance
`timescale 1ns/1ps
module nested_irq_ctrl_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [5:0]  adr_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        insn_done_i,
  input wire        irq_take_o,
  input wire [7:0]  vector_o,
  input wire        branch_if_masked_o,
  input wire        branch_if_unmasked_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_take; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("ack missing");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_prio3_ro; cyc_i && stb_i && !ack_o && !we_i && adr_i == 6'h0C
    |=> dat_o[7:4] == 4'hF; endproperty
  a_prio3_ro: assert property (p_prio3_ro) else $error("prio3 high bits");
  property p_mask_excl; branch_if_masked_o |-> !branch_if_unmasked_o; endproperty
  a_mask_excl: assert property (p_mask_excl) else $error("both branches");
  property p_rst_vec; $fell(rst_i) |=> irq_take_o && vector_o == 8'hFE; endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("no reset vector");
  property p_take_pulse; irq_take_o |=> !irq_take_o; endproperty
  a_take_pulse: assert property (p_take_pulse) else $error("take too long");
  property p_boundary; irq_take_o && vector_o[7:2] != 6'h3F |-> $past(insn_done_i);
  endproperty
  a_boundary: assert property (p_boundary) else $error("take mid insn");
  property p_vec_map; irq_take_o |-> vector_o >= 8'hE0 && !vector_o[0]; endproperty
  a_vec_map: assert property (p_vec_map) else $error("bad vector");
  property p_unused; irq_take_o |-> vector_o != 8'hFA && vector_o != 8'hEE; endproperty
  a_unused: assert property (p_unused) else $error("unused vector");
endmodule

bind nested_irq_ctrl nested_irq_ctrl_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .insn_done_i(insn_done_i),
  .irq_take_o(irq_take_o), .vector_o(vector_o),
  .branch_if_masked_o(branch_if_masked_o), .branch_if_unmasked_o(branch_if_unmasked_o)
);

// ---- verification/cpu_model.sv ----
// Purpose: CPU core side of the controller
// Assumes: Two cycles of stacking after each vector fetch
// Notes:   Records the last vector and counts fetches
`timescale 1ns/1ps
module cpu_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       irq_take_i,
  input  wire [7:0] vector_i,
  output reg        insn_done_o,
  output reg  [7:0] last_vec_o,
  output reg  [7:0] take_cnt_o
);
  reg [1:0] busy_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 2'h0;
      insn_done_o <= 1'b0;
      last_vec_o <= 8'h00;
      take_cnt_o <= 8'h00;
    end else begin
      insn_done_o <= (busy_r == 2'h0) && !irq_take_i;
      busy_r <= irq_take_i ? 2'h2 : (busy_r != 2'h0 ? busy_r - 2'h1 : 2'h0);
      if (irq_take_i) begin
        last_vec_o <= vector_i;
        take_cnt_o <= take_cnt_o + 8'h01;
      end
    end
  end
endmodule

// ---- verification/test_nested_irq_ctrl.sv ----
// Purpose: Register and servicing tests of nested_irq_ctrl
// Assumes: Wishbone classic master, 40 MHz clock
// Notes:   External lines idle high unless a scenario drives them
`timescale 1ns/1ps
`include "nested_irq_map.vh"
module test_nested_irq_ctrl;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc_i = 1'b0;
  reg         stb_i = 1'b0;
  reg         we_i = 1'b0;
  reg  [5:0]  adr_i = 6'h00;
  reg  [31:0] dat_i = 32'h0;
  reg  [13:0] periph_req_i = 14'h0;
  reg  [3:0]  ext_line_i = 4'hF;
  reg  [7:0]  wake_cnt = 8'h00;
  wire        wake_o;
  wire [31:0] dat_o;
  wire        ack_o, irq_take_o, insn_done_i, branch_if_masked_o, branch_if_unmasked_o;
  wire [7:0]  vector_o, last_vec, take_cnt;
  reg  [31:0] rd;
  reg  [7:0]  c;
  integer     err_count = 0;
  integer     tests_run = 0;
  integer     i;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (wake_o === 1'b1) begin
      wake_cnt <= wake_cnt + 8'h01;
    end
  end
  nested_irq_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .periph_req_i(periph_req_i), .ext_line_i(ext_line_i), .insn_done_i(insn_done_i),
    .irq_take_o(irq_take_o), .vector_o(vector_o), .branch_if_masked_o(branch_if_masked_o),
    .branch_if_unmasked_o(branch_if_unmasked_o), .wake_o(wake_o));
  cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_take_i(irq_take_o), .vector_i(vector_o),
    .insn_done_o(insn_done_i), .last_vec_o(last_vec), .take_cnt_o(take_cnt));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (err_count == 0 && tests_run > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  task wb(input w, input [5:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      n = 0;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge clk_i);
      end
      if (n == 50) err_count = err_count + 1;
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask
  task op(input [2:0] code);
    wb(1'b1, `ADR_CPU_OP, {29'h0, code});
  endtask
  task req(input [13:0] m);
    begin
      @(posedge clk_i);
      periph_req_i <= m;
      @(posedge clk_i);
      periph_req_i <= 14'h0;
    end
  endtask
  task take(input [7:0] v);
    integer n;
    begin
      n = 0;
      while (take_cnt === c && n < 100) begin
        n = n + 1;
        @(posedge clk_i);
      end
      check({24'h0, take_cnt}, {24'h0, c + 8'h01});
      check({24'h0, last_vec}, {24'h0, v});
      c = take_cnt;
    end
  endtask
  task lvl(input [7:0] e);
    begin
      wb(1'b0, `ADR_CCR, 32'h0);
      check(rd & 32'h28, {24'h0, e});
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({24'h0, last_vec}, 32'hFE);
    c = take_cnt;
    wb(1'b0, `ADR_CCR, 32'h0);
    check(rd & 32'hEF, 32'hEA);
    for (i = 0; i < 4; i = i + 1) begin
      wb(1'b0, {i[3:0], 2'b00}, 32'h0);
      check(rd, 32'hFF);
    end
    wb(1'b1, `ADR_PRIO0, 32'hCF);
    wb(1'b1, `ADR_PRIO0, 32'h64);
    wb(1'b0, `ADR_PRIO0, 32'h0);
    check(rd, 32'h44);
    wb(1'b1, `ADR_PRIO3, 32'h00);
    wb(1'b0, `ADR_PRIO3, 32'h0);
    check(rd, 32'hF0);
    wb(1'b1, `ADR_SENS, 32'hFC);
    wb(1'b0, `ADR_SENS, 32'h0);
    check(rd, 32'hFC);
    op(`OP_ENABLE);
    lvl(8'h20);
    check({31'h0, branch_if_unmasked_o}, 32'h1);
    wb(1'b1, `ADR_SENS, 32'h00);
    wb(1'b0, `ADR_SENS, 32'h0);
    check(rd, 32'hFC);
    op(`OP_DISABLE);
    lvl(8'h28);
    check({31'h0, branch_if_masked_o}, 32'h1);
    op(`OP_TRAP);
    take(8'hFC);
    op(`OP_RETURN);
    wb(1'b1, `ADR_PRIO1, 32'h7F);
    wb(1'b1, `ADR_REQ_EN, 32'h82);
    op(`OP_ENABLE);
    req(14'h0082);
    take(8'hF8);
    lvl(8'h08);
    repeat (20) @(posedge clk_i);
    check({24'h0, take_cnt}, {24'h0, c});
    wb(1'b1, `ADR_PEND, 32'h2);
    op(`OP_RETURN);
    take(8'hEC);
    wb(1'b1, `ADR_PEND, 32'h80);
    op(`OP_RETURN);
    wb(1'b1, `ADR_PRIO0, 32'h40);
    req(14'h0080);
    take(8'hEC);
    req(14'h0002);
    take(8'hF8);
    lvl(8'h00);
    wb(1'b1, `ADR_PEND, 32'h82);
    op(`OP_RETURN);
    op(`OP_RETURN);
    lvl(8'h20);
    op(`OP_DISABLE);
    wb(1'b1, `ADR_SENS, 32'h10);
    wb(1'b1, `ADR_REQ_EN, 32'h86);
    op(`OP_HALT);
    req(14'h0002);
    repeat (5) @(posedge clk_i);
    check({24'h0, wake_cnt}, 32'h0);
    wb(1'b0, `ADR_STATUS, 32'h0);
    check(rd & 32'h200, 32'h200);
    wb(1'b1, `ADR_PEND, 32'h2);
    @(posedge clk_i);
    ext_line_i <= 4'hE;
    take(8'hF6);
    check({24'h0, wake_cnt}, 32'h1);
    wb(1'b0, `ADR_PEND, 32'h0);
    check(rd, 32'h8000);
    @(posedge clk_i);
    ext_line_i <= 4'hF;
    op(`OP_RETURN);
    op(`OP_DISABLE);
    wb(1'b1, `ADR_SENS, 32'h00);
    @(posedge clk_i);
    ext_line_i <= 4'hE;
    wb(1'b1, `ADR_PEND, 32'h4);
    wb(1'b0, `ADR_PEND, 32'h0);
    check(rd & 32'h4, 32'h4);
    @(posedge clk_i);
    ext_line_i <= 4'hF;
    wb(1'b0, `ADR_PEND, 32'h0);
    check(rd & 32'h4, 32'h4);
    wb(1'b1, `ADR_PRIO0, 32'h70);
    wb(1'b0, `ADR_PEND, 32'h0);
    check(rd & 32'h4, 32'h0);
    wb(1'b1, `ADR_HALT_CTL, 32'h1);
    op(`OP_HALT);
    @(posedge clk_i);
    ext_line_i <= 4'hE;
    repeat (5) @(posedge clk_i);
    check({24'h0, wake_cnt}, 32'h1);
    req(14'h0002);
    take(8'hF8);
    check({24'h0, wake_cnt}, 32'h2);
    final_report;
  end
  initial begin
    #(25 * 5000);
    err_count = err_count + 1;
    final_report;
  end
endmodule
